// File: core/aue_pkg.sv
// Purpose: Shared constants and types for the uncorrectable error log.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Bit positions follow the status and mask layout.
package aue_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [11:0] AUE_OFS_STATUS   = 12'h104;
    localparam logic [11:0] AUE_OFS_MASK     = 12'h108;
    localparam logic [11:0] AUE_OFS_CTRL     = 12'h200;
    localparam logic [11:0] AUE_OFS_IRQ_STAT = 12'h204;
    localparam logic [11:0] AUE_OFS_IRQ_MASK = 12'h208;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int AUE_BIT_UNUSED     = 0;
    localparam int AUE_BIT_LINK_PROTO = 4;
    localparam int AUE_BIT_SURPRISE   = 5;
    localparam int AUE_BIT_POISONED   = 12;
    localparam int AUE_BIT_CREDIT     = 13;
    localparam int AUE_BIT_CPL_TO     = 14;
    localparam int AUE_BIT_CPL_ABORT  = 15;
    localparam int AUE_BIT_STRAY_CPL  = 16;
    localparam int AUE_BIT_RX_OVF     = 17;
    localparam int AUE_BIT_ILLEGAL    = 18;
    localparam int AUE_BIT_ECRC       = 19;
    localparam int AUE_BIT_UNSUPP     = 20;
    localparam int AUE_BIT_CTRL_SDCAP = 0;

    // ---------------------------------------------------------------
    // Reset values and implemented bits
    // ---------------------------------------------------------------
    localparam logic [31:0] AUE_RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] AUE_RST_MASK   = 32'h0000_0000;
    localparam logic [31:0] AUE_RST_CTRL   = 32'h0000_0000;
    localparam logic [31:0] AUE_IMPL_BITS  = 32'h001f_3031;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic link_protocol_violation;
        logic surprise_link_loss;
        logic poisoned_packet;
        logic credit_protocol_violation;
        logic stray_completion;
        logic receive_buffer_overflow;
        logic illegal_packet_format;
        logic ecrc_failure;
        logic unsupported_request;
    } aue_detect_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] errors;
    } aue_report_t;

    typedef enum logic [2:0] {
        AUE_SEL_NONE,
        AUE_SEL_STATUS,
        AUE_SEL_MASK,
        AUE_SEL_CTRL,
        AUE_SEL_IRQ_STAT,
        AUE_SEL_IRQ_MASK
    } aue_sel_t;

endpackage

// File: core/aue_error_log.sv
// Purpose: Sticky uncorrectable error status and mask registers of one port.
// Assumes: Detection pulses come from logic on pclk; one pulse per event.
// Notes:   presetn is the power-on reset, hot_reset_n spares the sticky bits except bit 5.
`timescale 1ns/1ps

module aue_error_log
    import aue_pkg::*;
(
    // Clock and resets
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        hot_reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Error detectors
    input  wire aue_detect_t detect,
    // Reporting
    output aue_report_t      report,
    output logic             irq
);

    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------
    function automatic aue_sel_t decode(input logic [11:0] addr);
        unique case (addr)
            AUE_OFS_STATUS:   decode = AUE_SEL_STATUS;
            AUE_OFS_MASK:     decode = AUE_SEL_MASK;
            AUE_OFS_CTRL:     decode = AUE_SEL_CTRL;
            AUE_OFS_IRQ_STAT: decode = AUE_SEL_IRQ_STAT;
            AUE_OFS_IRQ_MASK: decode = AUE_SEL_IRQ_MASK;
            default:          decode = AUE_SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] irq_stat_reg;
    logic [31:0] irq_stat_next;
    logic [31:0] irq_mask_reg;
    logic [31:0] prdata_reg;
    aue_report_t report_reg;

    aue_sel_t    sel;
    wire logic   setup_phase  = psel && !penable;
    wire logic   access_phase = psel && penable;
    wire logic   wr_fire      = access_phase && pwrite && sel != AUE_SEL_NONE;
    wire logic   rd_fire      = access_phase && !pwrite;
    wire logic [31:0] wmask   = strobe_mask(pstrb);
    wire logic [31:0] wbits   = pwdata & wmask;
    wire logic   sd_capable   = ctrl_reg[AUE_BIT_CTRL_SDCAP];

    assign sel     = decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = access_phase && sel == AUE_SEL_NONE;
    assign prdata  = prdata_reg;
    assign report  = report_reg;

    // ---------------------------------------------------------------
    // Event vector
    // ---------------------------------------------------------------
    logic [31:0] det_vec;
    always_comb begin
        det_vec = 32'h0000_0000;
        det_vec[AUE_BIT_LINK_PROTO] = detect.link_protocol_violation;
        det_vec[AUE_BIT_SURPRISE]   = detect.surprise_link_loss && sd_capable;
        det_vec[AUE_BIT_POISONED]   = detect.poisoned_packet;
        det_vec[AUE_BIT_CREDIT]     = detect.credit_protocol_violation;
        det_vec[AUE_BIT_STRAY_CPL]  = detect.stray_completion;
        det_vec[AUE_BIT_RX_OVF]     = detect.receive_buffer_overflow;
        det_vec[AUE_BIT_ILLEGAL]    = detect.illegal_packet_format;
        det_vec[AUE_BIT_ECRC]       = detect.ecrc_failure;
        det_vec[AUE_BIT_UNSUPP]     = detect.unsupported_request;
    end

    // Bit 0 and the hardwired bits never come from a detector.
    wire logic [31:0] event_bits = det_vec & AUE_IMPL_BITS & ~(32'h1 << AUE_BIT_UNUSED);
    wire logic [31:0] logged     = event_bits & ~mask_reg;

    // ---------------------------------------------------------------
    // Sticky status and mask
    // ---------------------------------------------------------------
    // A new event wins over a clear written in the same cycle, so nothing is lost.
    // Bit 5 follows the next value of the capability flag, so the bit and the flag
    // change at one edge and bit 5 never shows a stale cycle after the flag drops.
    assign ctrl_next = !hot_reset_n ? AUE_RST_CTRL
                     : (wr_fire && sel == AUE_SEL_CTRL)
                       ? ((ctrl_reg & ~wmask) | (wbits & (32'h1 << AUE_BIT_CTRL_SDCAP)))
                       : ctrl_reg;
    wire logic sd_next = ctrl_next[AUE_BIT_CTRL_SDCAP];
    wire logic [31:0] st_clear = (wr_fire && sel == AUE_SEL_STATUS) ? wbits : 32'h0;
    assign status_next = ((status_reg & ~st_clear) | logged) & AUE_IMPL_BITS
                         & ~({31'h0, !sd_next} << AUE_BIT_SURPRISE);

    assign mask_next = (wr_fire && sel == AUE_SEL_MASK)
                       ? (((mask_reg & ~wmask) | wbits) & AUE_IMPL_BITS)
                       : mask_reg;

    // Sticky bits see only presetn; hot reset clears only bit 5, through the capability flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= AUE_RST_STATUS;
            mask_reg   <= AUE_RST_MASK;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
        end
    end

    // ---------------------------------------------------------------
    // Control, interrupt and reporting (cleared by hot reset too)
    // ---------------------------------------------------------------
    wire logic irq_rd_clr = rd_fire && sel == AUE_SEL_IRQ_STAT;
    assign irq_stat_next = (irq_rd_clr ? 32'h0 : irq_stat_reg) | logged;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= AUE_RST_CTRL;
            irq_stat_reg <= 32'h0000_0000;
            irq_mask_reg <= 32'h0000_0000;
            report_reg   <= '0;
        end else if (!hot_reset_n) begin
            ctrl_reg     <= AUE_RST_CTRL;
            irq_stat_reg <= 32'h0000_0000;
            irq_mask_reg <= 32'h0000_0000;
            report_reg   <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            if (wr_fire && sel == AUE_SEL_IRQ_MASK) begin
                irq_mask_reg <= ((irq_mask_reg & ~wmask) | wbits) & AUE_IMPL_BITS;
            end
            irq_stat_reg <= irq_stat_next;
            report_reg   <= '{valid: |logged, errors: logged};
        end
    end

    assign irq = |(irq_stat_reg & ~irq_mask_reg);

    // ---------------------------------------------------------------
    // Read data, captured in the setup phase
    // ---------------------------------------------------------------
    // Captured one cycle early so prdata comes from a flop; a clear that lands
    // in that same cycle is not yet visible in the returned word.
    logic [31:0] rd_mux;
    always_comb begin
        unique case (sel)
            AUE_SEL_STATUS:   rd_mux = status_reg;
            AUE_SEL_MASK:     rd_mux = mask_reg;
            AUE_SEL_CTRL:     rd_mux = ctrl_reg;
            AUE_SEL_IRQ_STAT: rd_mux = irq_stat_reg;
            AUE_SEL_IRQ_MASK: rd_mux = irq_mask_reg;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_link_proto;
        detect.link_protocol_violation && !mask_reg[AUE_BIT_LINK_PROTO]
            |=> status_reg[AUE_BIT_LINK_PROTO];
    endproperty
    a_link_proto: assert property (p_link_proto) else $error("link protocol bit not set");

    property p_surprise;
        detect.surprise_link_loss && sd_capable && !mask_reg[AUE_BIT_SURPRISE]
            |=> status_reg[AUE_BIT_SURPRISE] || !sd_capable;
    endproperty
    a_surprise: assert property (p_surprise) else $error("surprise loss bit not set");

    property p_surprise_zero;
        !sd_capable |-> !status_reg[AUE_BIT_SURPRISE];
    endproperty
    a_surprise_zero: assert property (p_surprise_zero) else $error("surprise bit not zero");

    // No clear is excluded: an event in the cycle of a clear must still win.
    property p_unsupp_held;
        detect.unsupported_request && !mask_reg[AUE_BIT_UNSUPP]
            |=> status_reg[AUE_BIT_UNSUPP];
    endproperty
    a_unsupp_held: assert property (p_unsupp_held) else $error("unsupported bit lost");

    property p_hardwired;
        status_reg[AUE_BIT_CPL_TO] == 1'b0 && status_reg[AUE_BIT_CPL_ABORT] == 1'b0
            && mask_reg[AUE_BIT_CPL_TO] == 1'b0 && mask_reg[AUE_BIT_CPL_ABORT] == 1'b0;
    endproperty
    a_hardwired: assert property (p_hardwired) else $error("hardwired bits set");

    property p_masked;
        detect.poisoned_packet && mask_reg[AUE_BIT_POISONED] && !status_reg[AUE_BIT_POISONED]
            |=> !status_reg[AUE_BIT_POISONED] && !report_reg.errors[AUE_BIT_POISONED];
    endproperty
    a_masked: assert property (p_masked) else $error("masked event logged");

    property p_unused;
        !status_reg[AUE_BIT_UNUSED] |=> !status_reg[AUE_BIT_UNUSED];
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set by event");

    sequence s_clear_credit;
        wr_fire && sel == AUE_SEL_STATUS && wbits[AUE_BIT_CREDIT]
            && !logged[AUE_BIT_CREDIT];
    endsequence
    property p_w1c;
        s_clear_credit |=> !status_reg[AUE_BIT_CREDIT];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_w0_keep;
        wr_fire && sel == AUE_SEL_STATUS && !wbits[AUE_BIT_ECRC] && status_reg[AUE_BIT_ECRC]
            |=> status_reg[AUE_BIT_ECRC];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("write zero changed a bit");

    property p_hot_reset;
        !hot_reset_n && !wr_fire
            |=> ((status_reg | (32'h1 << AUE_BIT_SURPRISE))
                 == ($past(status_reg) | $past(logged) | (32'h1 << AUE_BIT_SURPRISE)))
                && mask_reg == $past(mask_reg);
    endproperty
    a_hot_reset: assert property (p_hot_reset) else $error("sticky bits lost");

    property p_irq;
        |(logged & ~irq_mask_reg) && hot_reset_n && !(wr_fire && sel == AUE_SEL_IRQ_MASK)
            |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_poisoned;
        detect.poisoned_packet && !mask_reg[AUE_BIT_POISONED]
            |=> status_reg[AUE_BIT_POISONED];
    endproperty
    a_poisoned: assert property (p_poisoned) else $error("poisoned bit not set");

    property p_credit;
        detect.credit_protocol_violation && !mask_reg[AUE_BIT_CREDIT]
            |=> status_reg[AUE_BIT_CREDIT];
    endproperty
    a_credit: assert property (p_credit) else $error("credit bit not set");

    property p_stray;
        detect.stray_completion && !mask_reg[AUE_BIT_STRAY_CPL]
            |=> status_reg[AUE_BIT_STRAY_CPL];
    endproperty
    a_stray: assert property (p_stray) else $error("stray completion bit not set");

    property p_rx_ovf;
        detect.receive_buffer_overflow && !mask_reg[AUE_BIT_RX_OVF]
            |=> status_reg[AUE_BIT_RX_OVF];
    endproperty
    a_rx_ovf: assert property (p_rx_ovf) else $error("overflow bit not set");

    property p_illegal;
        detect.illegal_packet_format && !mask_reg[AUE_BIT_ILLEGAL]
            |=> status_reg[AUE_BIT_ILLEGAL];
    endproperty
    a_illegal: assert property (p_illegal) else $error("format bit not set");

    property p_ecrc;
        detect.ecrc_failure && !mask_reg[AUE_BIT_ECRC]
            |=> status_reg[AUE_BIT_ECRC];
    endproperty
    a_ecrc: assert property (p_ecrc) else $error("crc bit not set");

    property p_sd_refused;
        detect.surprise_link_loss && !sd_capable
            |=> !status_reg[AUE_BIT_SURPRISE] && !report_reg.errors[AUE_BIT_SURPRISE];
    endproperty
    a_sd_refused: assert property (p_sd_refused) else $error("bit 5 logged");

    sequence s_report_unsupp;
        report_reg.valid && report_reg.errors[AUE_BIT_UNSUPP];
    endsequence
    property p_report;
        detect.unsupported_request && !mask_reg[AUE_BIT_UNSUPP] && hot_reset_n
            |=> s_report_unsupp;
    endproperty
    a_report: assert property (p_report) else $error("event not reported");

    property p_masked_link;
        detect.link_protocol_violation && mask_reg[AUE_BIT_LINK_PROTO]
            && !status_reg[AUE_BIT_LINK_PROTO]
            |=> !status_reg[AUE_BIT_LINK_PROTO] && !report_reg.errors[AUE_BIT_LINK_PROTO];
    endproperty
    a_masked_link: assert property (p_masked_link) else $error("masked link logged");

    property p_report_idle;
        detect == '0 |=> !report_reg.valid;
    endproperty
    a_report_idle: assert property (p_report_idle) else $error("report without event");

    sequence s_mask_wr_low;
        wr_fire && sel == AUE_SEL_MASK && pstrb[0];
    endsequence
    property p_mask_bit0_set;
        s_mask_wr_low ##0 pwdata[AUE_BIT_UNUSED] |=> mask_reg[AUE_BIT_UNUSED];
    endproperty
    a_mask_bit0_set: assert property (p_mask_bit0_set) else $error("bit 0 lost");

    property p_mask_bit0_clr;
        s_mask_wr_low ##0 !pwdata[AUE_BIT_UNUSED] |=> !mask_reg[AUE_BIT_UNUSED];
    endproperty
    a_mask_bit0_clr: assert property (p_mask_bit0_clr) else $error("bit 0 stuck");

    property p_mask_write;
        wr_fire && sel == AUE_SEL_MASK && pstrb == 4'hf
            |=> mask_reg == ($past(pwdata) & AUE_IMPL_BITS);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

    property p_reserved;
        ((status_reg | mask_reg) & ~AUE_IMPL_BITS) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_rd_status;
        setup_phase && !pwrite && sel == AUE_SEL_STATUS
            |=> prdata == $past(status_reg);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");

    property p_unmapped_wr;
        access_phase && pwrite && sel == AUE_SEL_NONE && logged == 32'h0 && hot_reset_n
            |=> status_reg == $past(status_reg) && mask_reg == $past(mask_reg);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

    property p_hot_side;
        !hot_reset_n |=> !sd_capable && irq_stat_reg == 32'h0000_0000 && !report_reg.valid;
    endproperty
    a_hot_side: assert property (p_hot_side) else $error("hot reset left state");

    property p_irq_clear;
        irq_rd_clr && logged == 32'h0000_0000 && hot_reset_n |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

endmodule

// File: tb/aue_sw_model.sv
// Purpose: Configuration software model that reaches the error log over APB.
// Assumes: The slave may hold pready low for any number of cycles.
// Notes:   The testbench calls xfer hierarchically; one transfer per call.
`timescale 1ns/1ps

module aue_sw_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ---------------------------------------------------------------
    // Transfers
    // ---------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
    end

    // Logged errors are cleared by writing ones, so a write of zero is harmless.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// File: tb/aue_error_log_test.sv
// Purpose: Self-checking bench for the uncorrectable error log.
// Assumes: Zero wait-state APB slave; detection pulses last one cycle.
// Notes:   Expected values are built from bit positions, not from the design.
`timescale 1ns/1ps

module aue_error_log_test;
    import aue_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        hot_reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    aue_detect_t detect;
    aue_report_t report;
    logic        irq;
    logic [31:0] v;
    logic        e;
    int          error_cnt;
    int          compares;
    int          cycles = 0;
    int          bitpos [9] = '{20, 19, 18, 17, 16, 13, 12, 5, 4};

    aue_error_log aue_error_log_inst (.pclk(pclk), .presetn(presetn),
        .hot_reset_n(hot_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .detect(detect), .report(report), .irq(irq));
    aue_sw_model aue_sw_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    always #20 pclk = ~pclk;

    // A hang would otherwise stall the run silently.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            results();
        end
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The short wait lets outputs launched at the access edge settle before a compare.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] r;
        logic        x;
        aue_sw_model_inst.xfer(1'b1, a, d, s, r, x);
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        aue_sw_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'h0, v, e);
        #1;
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge pclk);
        detect <= aue_detect_t'(m);
        @(posedge pclk);
        detect <= '0;
        #1;
    endtask
    task automatic results();
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_events();
        wr(AUE_OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 9; i++) begin
            pulse(9'h001 << i);
            chk({30'h0, report.valid, report.errors[bitpos[i]]}, 32'h3);
            rd(AUE_OFS_STATUS);
            chk(v, 32'h1 << bitpos[i]);
            wr(AUE_OFS_STATUS, 32'h1 << bitpos[i]);
        end
        pulse(9'h1ff);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h001f_3030);
        wr(AUE_OFS_STATUS, 32'h0000_0000);
        wr(AUE_OFS_STATUS, 32'h0000_1010);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h001f_2020);
        wr(AUE_OFS_STATUS, 32'hffff_ffff, 4'h4);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_2020);
        wr(AUE_OFS_STATUS, 32'hffff_ffff);
        $display("t_events done");
    endtask

    task automatic t_mask();
        wr(AUE_OFS_MASK, 32'hffff_ffff);
        rd(AUE_OFS_MASK);
        chk(v, 32'h001f_3031);
        pulse(9'h1ff);
        chk({31'h0, report.valid}, 32'h0);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0000);
        wr(AUE_OFS_MASK, 32'h0000_1000);
        pulse(9'h140);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0010);
        wr(AUE_OFS_STATUS, 32'hffff_ffff);
        wr(AUE_OFS_MASK, 32'h0000_0000);
        $display("t_mask done");
    endtask

    task automatic t_surprise();
        wr(AUE_OFS_CTRL, 32'h0000_0000);
        pulse(9'h080);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0000);
        wr(AUE_OFS_CTRL, 32'h0000_0001);
        pulse(9'h080);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0020);
        wr(AUE_OFS_CTRL, 32'h0000_0000);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0000);
        $display("t_surprise done");
    endtask

    task automatic t_irq();
        rd(AUE_OFS_IRQ_STAT);
        chk({31'h0, irq}, 32'h0);
        wr(AUE_OFS_IRQ_MASK, 32'hffff_ffff);
        pulse(9'h001);
        chk({31'h0, irq}, 32'h0);
        wr(AUE_OFS_IRQ_MASK, 32'h0000_0000);
        chk({31'h0, irq}, 32'h1);
        rd(AUE_OFS_IRQ_STAT);
        chk(v, 32'h0010_0000);
        chk({31'h0, irq}, 32'h0);
        rd(12'h300);
        chk({e, v[30:0]}, 32'h8000_0000);
        chk({31'h0, pready}, 32'h1);
        wr(12'h300, 32'hffff_ffff);
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0010_0000);
        wr(AUE_OFS_STATUS, 32'hffff_ffff);
        $display("t_irq done");
    endtask

    task automatic t_sticky();
        wr(AUE_OFS_CTRL, 32'h0000_0001);
        pulse(9'h040);
        wr(AUE_OFS_MASK, 32'h0008_0001);
        @(posedge pclk);
        hot_reset_n <= 1'b0;
        repeat (2) @(posedge pclk);
        hot_reset_n <= 1'b1;
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_1000);
        rd(AUE_OFS_MASK);
        chk(v, 32'h0008_0001);
        rd(AUE_OFS_CTRL);
        chk(v, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0000);
        rd(AUE_OFS_MASK);
        chk(v, 32'h0000_0000);
        $display("t_sticky done");
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        hot_reset_n = 1'b1;
        detect = '0;
        error_cnt = 0;
        compares = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(AUE_OFS_STATUS);
        chk(v, 32'h0000_0000);
        t_events();
        t_mask();
        t_surprise();
        t_irq();
        t_sticky();
        results();
    end
endmodule
